/* hdl/ldr_pkg.sv */
// Package for the LED dimming reference and calibration block
package ldr_pkg;
    localparam int ADIM_W = 8;
    localparam int CAL_W = 8;
    localparam logic [7:0] ADIM_RESET = 8'h00;
    localparam logic [7:0] ADIM_FULL = 8'hF0;
    localparam logic [7:0] CAL_RESET = 8'h00;
    localparam logic [2:0] DSCHG_DLY_DEFAULT = 3'h0;
    localparam int CLK_HZ = 40000000;
    localparam int CAL_TIME_US = 200;
    localparam int CAL_CYCLES = (CAL_TIME_US * (CLK_HZ / 1000000));
    localparam int DLY_UNIT_CYCLES = 16;

    typedef enum logic [3:0] {
        LDR_NORMAL = 4'h1,
        LDR_DISCHARGE = 4'h2,
        LDR_LIMP = 4'h4,
        LDR_LIMP_WAIT = 4'h8
    } ldr_mode_t;

    typedef struct packed {
        logic sel_set_pin;
        logic [7:0] level;
    } ldr_ref_t;

    typedef struct packed {
        logic enable;
        logic start;
        logic [7:0] wr_value;
    } ldr_cal_ctrl_t;
endpackage : ldr_pkg

/* hdl/ldr_cal_engine.sv */
// Offset calibration sequencer with done flag and value selection
`timescale 1ns/1ps
`default_nettype none
module ldr_cal_engine #(
    parameter int CAL_CYCLES = ldr_pkg::CAL_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire ldr_pkg::ldr_cal_ctrl_t ctrl,
    input wire logic [7:0] measured,
    output logic busy,
    output logic done,
    output logic [7:0] value
);
    logic [31:0] cnt_ff, nxt_cnt;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic [7:0] res_ff, nxt_res;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_busy = busy_ff;
        nxt_done = done_ff;
        nxt_res = res_ff;
        if (busy_ff) begin
            if (!ctrl.enable) begin
                nxt_busy = 1'b0;
            end else if (cnt_ff == 32'(CAL_CYCLES - 1)) begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                nxt_res = measured;
            end else begin
                nxt_cnt = cnt_ff + 32'h1;
            end
        end else if (ctrl.start && ctrl.enable) begin
            nxt_busy = 1'b1;
            nxt_cnt = 32'h0;
            nxt_done = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 32'h0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            res_ff <= ldr_pkg::CAL_RESET;
        end else begin
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            res_ff <= nxt_res;
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;
    // Routine result or host value, per enable bit
    assign value = ctrl.enable ? res_ff : ctrl.wr_value;

    a_cal_ignored: assert property (@(posedge clock) disable iff (!arst_n)
        (!busy_ff && ctrl.start && !ctrl.enable) |=> !busy_ff)
        else $error("calibration started while disabled");
    a_cal_clears_done: assert property (@(posedge clock) disable iff (!arst_n)
        (!busy_ff && ctrl.start && ctrl.enable) |=> (busy_ff && !done_ff))
        else $error("done flag not cleared on start");
    a_cal_done_set: assert property (@(posedge clock) disable iff (!arst_n)
        (busy_ff && ctrl.enable && cnt_ff == 32'(CAL_CYCLES - 1)) |=> done_ff)
        else $error("done flag not set after routine");
endmodule : ldr_cal_engine
`default_nettype wire

/* hdl/ldr_top.sv */
// LED dimming reference selection, limp-home control and calibration
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Default reference is SPI 8-bit level
// - Select bit uses min of set-pin, DAC
// - Limp-home input high enters limp-home
// - Switching needs dimming and enable high
// - Limp-home uses set pin, select flags set-pin source
// - Limp-home entry discharges with default delay
// - After discharge regulate only if dimming high
// - Calibration routine lasts about 200 us
// - Done flag set when routine ends
// - Result applied to dimming reference
// - Enable high uses and reads result
// - Enable low uses and reads host value
// - Start ignored while enable low
// - No correction at full dimming level
// - Gate drivers follow dimming input
module ldr_top #(
    parameter int CAL_CYCLES = ldr_pkg::CAL_CYCLES,
    parameter int DLY_UNIT = ldr_pkg::DLY_UNIT_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic limp_home_in,
    input wire logic dim_pulse_in,
    input wire logic enable_uvlo_in,
    input wire logic dac_off,
    input wire logic [7:0] analog_dim_level,
    input wire logic [7:0] set_pin_level,
    input wire logic [2:0] discharge_delay_cfg,
    input wire logic s2g_below,
    input wire logic cal_enable,
    input wire logic cal_start,
    input wire logic [7:0] cal_value_wr,
    input wire logic [7:0] cal_measured,
    output logic gate_enable,
    output logic discharge_active,
    output logic limp_home_active,
    output logic [7:0] ref_level,
    output logic ref_from_set_pin,
    output logic cal_busy,
    output logic cal_done,
    output logic [7:0] cal_value
);
    ldr_pkg::ldr_mode_t mode_ff, nxt_mode;
    logic [15:0] dly_ff, nxt_dly;
    logic gate_ff, nxt_gate;
    logic dsch_ff, nxt_dsch;
    logic limp_ff, nxt_limp;
    ldr_pkg::ldr_ref_t ref_ff, nxt_ref;
    logic cbusy_ff, cdone_ff;
    logic [7:0] cval_ff;
    logic eng_busy, eng_done;
    logic [7:0] eng_value;
    ldr_pkg::ldr_cal_ctrl_t cal_ctrl;
    logic [7:0] dac_corr;
    logic [8:0] corr_sum;
    logic [15:0] dsch_len;

    assign cal_ctrl = '{enable: cal_enable, start: cal_start, wr_value: cal_value_wr};

    ldr_cal_engine #(
        .CAL_CYCLES(CAL_CYCLES)
    ) u_cal (
        .clock(clock),
        .arst_n(arst_n),
        .ctrl(cal_ctrl),
        .measured(cal_measured),
        .busy(eng_busy),
        .done(eng_done),
        .value(eng_value)
    );

    // Offset as signed byte; full level bypasses correction
    assign corr_sum = {1'b0, analog_dim_level} + {eng_value[7], eng_value};
    always_comb begin
        if (analog_dim_level >= ldr_pkg::ADIM_FULL) begin
            dac_corr = analog_dim_level;
        end else if (corr_sum[8] && !eng_value[7]) begin
            dac_corr = 8'hFF;
        end else if (!corr_sum[8] && eng_value[7]) begin
            dac_corr = 8'h00;
        end else begin
            dac_corr = corr_sum[7:0];
        end
    end

    // Limp-home discharge ignores the host setting
    assign dsch_len = 16'((32'(ldr_pkg::DSCHG_DLY_DEFAULT) + 1) * DLY_UNIT);

    always_comb begin
        nxt_mode = mode_ff;
        nxt_dly = dly_ff;
        unique case (mode_ff)
            ldr_pkg::LDR_NORMAL: begin
                if (limp_home_in) begin
                    nxt_mode = ldr_pkg::LDR_DISCHARGE;
                    nxt_dly = 16'h0;
                end
            end
            ldr_pkg::LDR_DISCHARGE: begin
                if (!limp_home_in) begin
                    nxt_mode = ldr_pkg::LDR_NORMAL;
                end else if (s2g_below && dly_ff >= dsch_len) begin
                    nxt_mode = ldr_pkg::LDR_LIMP_WAIT;
                end else if (dly_ff != 16'hFFFF) begin
                    nxt_dly = dly_ff + 16'h1;
                end
            end
            ldr_pkg::LDR_LIMP_WAIT: begin
                if (!limp_home_in) begin
                    nxt_mode = ldr_pkg::LDR_NORMAL;
                end else if (dim_pulse_in) begin
                    nxt_mode = ldr_pkg::LDR_LIMP;
                end
            end
            ldr_pkg::LDR_LIMP: begin
                if (!limp_home_in) begin
                    nxt_mode = ldr_pkg::LDR_NORMAL;
                end
            end
            default: begin
                nxt_mode = ldr_pkg::LDR_NORMAL;
            end
        endcase
    end

    always_comb begin
        nxt_limp = (nxt_mode != ldr_pkg::LDR_NORMAL);
        nxt_dsch = (nxt_mode == ldr_pkg::LDR_DISCHARGE);
        // No switching during discharge or while waiting for dimming
        nxt_gate = dim_pulse_in && enable_uvlo_in
            && (nxt_mode == ldr_pkg::LDR_NORMAL || nxt_mode == ldr_pkg::LDR_LIMP);
        nxt_ref.sel_set_pin = nxt_limp || dac_off;
        if (nxt_limp) begin
            nxt_ref.level = set_pin_level;
        end else if (dac_off) begin
            nxt_ref.level = (set_pin_level < dac_corr) ? set_pin_level : dac_corr;
        end else begin
            nxt_ref.level = dac_corr;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mode_ff <= ldr_pkg::LDR_NORMAL;
            dly_ff <= 16'h0;
            gate_ff <= 1'b0;
            dsch_ff <= 1'b0;
            limp_ff <= 1'b0;
            ref_ff <= '{sel_set_pin: 1'b0, level: ldr_pkg::ADIM_RESET};
            cbusy_ff <= 1'b0;
            cdone_ff <= 1'b0;
            cval_ff <= ldr_pkg::CAL_RESET;
        end else begin
            mode_ff <= nxt_mode;
            dly_ff <= nxt_dly;
            gate_ff <= nxt_gate;
            dsch_ff <= nxt_dsch;
            limp_ff <= nxt_limp;
            ref_ff <= nxt_ref;
            cbusy_ff <= eng_busy;
            cdone_ff <= eng_done;
            cval_ff <= eng_value;
        end
    end

    assign gate_enable = gate_ff;
    assign discharge_active = dsch_ff;
    assign limp_home_active = limp_ff;
    assign ref_level = ref_ff.level;
    assign ref_from_set_pin = ref_ff.sel_set_pin;
    assign cal_busy = cbusy_ff;
    assign cal_done = cdone_ff;
    assign cal_value = cval_ff;

    sequence s_limp_rise;
        !limp_home_in ##1 limp_home_in;
    endsequence

    a_gate_needs_pins: assert property (@(posedge clock) disable iff (!arst_n)
        gate_ff |-> ($past(dim_pulse_in) && $past(enable_uvlo_in)))
        else $error("gate enabled without dimming and enable");
    a_limp_enter: assert property (@(posedge clock) disable iff (!arst_n)
        (mode_ff == ldr_pkg::LDR_NORMAL && limp_home_in) |=> (limp_ff && dsch_ff))
        else $error("limp-home not entered");
    a_limp_discharge: assert property (@(posedge clock) disable iff (!arst_n)
        (s_limp_rise and (mode_ff == ldr_pkg::LDR_NORMAL)) |=> !gate_ff)
        else $error("switching during discharge");
    a_limp_set_pin: assert property (@(posedge clock) disable iff (!arst_n)
        limp_ff |-> (ref_ff.sel_set_pin && ref_ff.level == $past(set_pin_level)))
        else $error("limp-home reference not from set pin");
    a_ref_minimum: assert property (@(posedge clock) disable iff (!arst_n)
        (!limp_ff && $past(dac_off)) |-> (ref_ff.level <= $past(set_pin_level)))
        else $error("reference above set pin");
    a_ref_full_scale: assert property (@(posedge clock) disable iff (!arst_n)
        (!limp_ff && !$past(dac_off) && $past(analog_dim_level) >= ldr_pkg::ADIM_FULL)
        |-> (ref_ff.level == $past(analog_dim_level)))
        else $error("correction applied at full scale");
    a_wait_no_gate: assert property (@(posedge clock) disable iff (!arst_n)
        (mode_ff == ldr_pkg::LDR_LIMP_WAIT) |-> !gate_ff)
        else $error("regulating before dimming input high");
    a_limp_restart: assert property (@(posedge clock) disable iff (!arst_n)
        (mode_ff == ldr_pkg::LDR_LIMP_WAIT && limp_home_in && dim_pulse_in && enable_uvlo_in) |=> gate_ff)
        else $error("no restart after limp-home discharge");
    a_gate_dim_low: assert property (@(posedge clock) disable iff (!arst_n)
        !dim_pulse_in |=> !gate_ff)
        else $error("gate enabled while dimming input low");
    a_limp_exit: assert property (@(posedge clock) disable iff (!arst_n)
        (limp_ff && !limp_home_in) |=> !limp_ff)
        else $error("limp-home not left");
    // Early end would leave charge on the output for the next load
    a_dsch_min_len: assert property (@(posedge clock) disable iff (!arst_n)
        (dsch_ff && limp_home_in && !nxt_dsch) |-> (dly_ff >= dsch_len))
        else $error("discharge ended before default delay");
endmodule : ldr_top
`default_nettype wire

/* bench/ldr_plant_model.sv */
// Output stage and calibration front end seen by the block
`timescale 1ns/1ps
`default_nettype none
module ldr_plant_model #(
    parameter int S2G_DELAY = 30,
    parameter logic [7:0] CAL_RESULT = 8'h05
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic discharge_active,
    output logic s2g_below,
    output logic [7:0] cal_measured
);
    int cnt_ff;
    // Output voltage falls slowly, so the threshold is reached well after the minimum delay
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 0;
        end else begin
            cnt_ff <= discharge_active ? cnt_ff + 1 : 0;
        end
    end
    assign s2g_below = (cnt_ff >= S2G_DELAY);
    // Zero load current during the run gives a fixed offset result
    assign cal_measured = CAL_RESULT;
endmodule : ldr_plant_model
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the dimming reference and calibration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module tb;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic limp_home_in = 1'b0, dim_pulse_in = 1'b0, enable_uvlo_in = 1'b1, dac_off = 1'b0;
    logic [7:0] analog_dim_level = 8'h50, set_pin_level = 8'h40, cal_value_wr = 8'h00;
    logic [2:0] discharge_delay_cfg = 3'h7;
    logic s2g_below, cal_enable = 1'b0, cal_start = 1'b0, gate_enable, discharge_active, limp_home_active;
    logic [7:0] cal_measured, ref_level, cal_value;
    logic ref_from_set_pin, cal_busy, cal_done;
    int n_errors = 0;
    int compares = 0;
    localparam int CAL_N = 20;
    ldr_top #(.CAL_CYCLES(CAL_N), .DLY_UNIT(16)) ldr_top_i (.clock(clock), .arst_n(arst_n),
        .limp_home_in(limp_home_in), .dim_pulse_in(dim_pulse_in), .enable_uvlo_in(enable_uvlo_in),
        .dac_off(dac_off), .analog_dim_level(analog_dim_level), .set_pin_level(set_pin_level),
        .discharge_delay_cfg(discharge_delay_cfg), .s2g_below(s2g_below), .cal_enable(cal_enable),
        .cal_start(cal_start), .cal_value_wr(cal_value_wr), .cal_measured(cal_measured),
        .gate_enable(gate_enable), .discharge_active(discharge_active), .limp_home_active(limp_home_active),
        .ref_level(ref_level), .ref_from_set_pin(ref_from_set_pin), .cal_busy(cal_busy),
        .cal_done(cal_done), .cal_value(cal_value));
    ldr_plant_model ldr_plant_model_i (.clock(clock), .arst_n(arst_n), .discharge_active(discharge_active),
        .s2g_below(s2g_below), .cal_measured(cal_measured));
    initial begin
        forever #12.5 clock = ~clock;
    end
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    // Limp-home entry, discharge, then restart decided by the dimming input
    task automatic run_limp(input logic dim, input logic exp_gate);
        int n;
        @(posedge clock);
        dim_pulse_in <= dim;
        limp_home_in <= 1'b1;
        settle(1);
        `CHK("limp active", 1'b1, limp_home_active)
        `CHK("discharge start", 1'b1, discharge_active)
        `CHK("gate in discharge", 1'b0, gate_enable)
        n = 1;
        while (discharge_active === 1'b1 && n < 200) begin
            settle(1);
            n++;
        end
        // Host delay setting is large, so a short discharge shows the default was used
        `CHK("discharge length", 1'b1, (n > 16 && n < 40))
        settle(2);
        `CHK("gate after discharge", exp_gate, gate_enable)
        `CHK("limp ref level", 8'h40, ref_level)
        `CHK("limp ref source", 1'b1, ref_from_set_pin)
        @(posedge clock);
        limp_home_in <= 1'b0;
        settle(2);
        `CHK("limp left", 1'b0, limp_home_active)
    endtask : run_limp
    task automatic start_cal();
        int n;
        @(posedge clock);
        cal_start <= 1'b1;
        @(posedge clock);
        cal_start <= 1'b0;
        settle(2);
        `CHK("cal busy", 1'b1, cal_busy)
        `CHK("done cleared", 1'b0, cal_done)
        n = 2;
        while (cal_done !== 1'b1 && n < 200) begin
            settle(1);
            n++;
        end
        `CHK("cal duration", CAL_N + 1, n)
    endtask : start_cal
    initial begin
        #(25ns * 6000);
        n_errors++;
        test_done();
    end
    initial begin
        settle(15);
        `CHK("reset gate", 1'b0, gate_enable)
        `CHK("reset ref", 8'h00, ref_level)
        `CHK("reset done", 1'b0, cal_done)
        @(posedge clock);
        arst_n <= 1'b1;
        settle(4);
        `CHK("spi ref", 8'h50, ref_level)
        `CHK("spi source", 1'b0, ref_from_set_pin)
        @(posedge clock) dim_pulse_in <= 1'b1;
        settle(2);
        `CHK("gate on", 1'b1, gate_enable)
        @(posedge clock) enable_uvlo_in <= 1'b0;
        settle(2);
        `CHK("gate no enable", 1'b0, gate_enable)
        @(posedge clock) {enable_uvlo_in, dim_pulse_in} <= 2'b10;
        settle(2);
        `CHK("gate dim low", 1'b0, gate_enable)
        @(posedge clock) {dac_off, set_pin_level} <= {1'b1, 8'h30};
        settle(3);
        `CHK("min set pin", 8'h30, ref_level)
        `CHK("select source", 1'b1, ref_from_set_pin)
        @(posedge clock) set_pin_level <= 8'h90;
        settle(3);
        `CHK("min dac", 8'h50, ref_level)
        @(posedge clock) {dac_off, set_pin_level} <= {1'b0, 8'h40};
        run_limp(1'b1, 1'b1);
        run_limp(1'b0, 1'b0);
        // Dimming input stays low through every run
        @(posedge clock) {dim_pulse_in, cal_start} <= 2'b01;
        settle(4);
        `CHK("start refused", 1'b0, cal_busy)
        @(posedge clock) cal_start <= 1'b0;
        @(posedge clock) cal_enable <= 1'b1;
        start_cal();
        settle(3);
        `CHK("result readback", 8'h05, cal_value)
        `CHK("corrected ref", 8'h55, ref_level)
        @(posedge clock) analog_dim_level <= 8'hF0;
        settle(3);
        `CHK("full scale ref", 8'hF0, ref_level)
        @(posedge clock) analog_dim_level <= 8'h50;
        start_cal();
        @(posedge clock) {cal_enable, cal_value_wr} <= {1'b0, 8'h03};
        settle(4);
        `CHK("host value", 8'h03, cal_value)
        `CHK("host corrected ref", 8'h53, ref_level)
        `CHK("done sticky", 1'b1, cal_done)
        @(posedge clock) {dac_off, analog_dim_level, set_pin_level} <= {1'b1, 8'hF0, 8'hC8};
        settle(3);
        `CHK("set pin full scale", 8'hC8, ref_level)
        test_done();
    end
endmodule : tb
`default_nettype wire
